// [include/usr_pkg.sv]
// Constants for the reset, suspend and local bus pin block
// Summary of operation
// - Local clock output stops and floats as soon as suspend starts; after a suspend command it floats one cycle later.
// - After oscillator restart the local clock output stays undriven for 2 ms.
// - Local clock output does not toggle in power-down mode.
// - Oscillator is stopped while suspended.
// - Reset pin returns every register and pointer to its default.
// - Falling address latch strobe captures a 5-bit address from low data bits.
// - Use of the address latch strobe is detected without configuration.
// - One address bit suffices through pointer-indirect access; five address directly.
// - Chip select during suspend wakes the device.
// - Chip select held during reset keeps the oscillator off.
// - Open-drain interrupt pulls low while any enabled event is pending.
// - DMA request floats while suspended; its polarity is programmable.
// - DMA acknowledge ignored unless enabled; its polarity is programmable.
// - Transfer end finishes current word, stops requests, may interrupt; polarity programmable.
// - Single-ended zero longer than 2.5 us is a bus reset.
// - Bus reset detection needs VBUS high and detection enabled.
// - Bus reset clears USB logic, device address, pointers and the transfer end stop state only.
// - Bus reset flag sets on both start and end of bus reset.
// - VBUS input indicates attachment to a powered host.
package usr_pkg;
  localparam logic [7:0] USR_CTL_OFS = 8'h00;
  localparam logic [7:0] USR_IRQ_EN_OFS = 8'h04;
  localparam logic [7:0] USR_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] USR_STATUS_OFS = 8'h0C;
  localparam logic [7:0] USR_DEV_ADDR_OFS = 8'h10;
  localparam int USR_CTL_DETECT_EN = 0;
  localparam int USR_CTL_ACK_EN = 1;
  localparam int USR_CTL_DMA_REQUEST_POL = 2;
  localparam int USR_CTL_DMA_ACKNOWLEDGE_POL = 3;
  localparam int USR_CTL_EOT_POL = 4;
  localparam int USR_CTL_DMA_EN = 5;
  localparam int USR_CTL_SUSPEND = 6;
  localparam int USR_CTL_PWR_DOWN = 7;
  localparam int USR_CTL_CLK_EN = 8;
  localparam int USR_CTL_DIV_LSB = 12;
  localparam logic [15:0] USR_CTL_RESET = 16'h0104;
  localparam int USR_IRQ_BUSRST = 0;
  localparam int USR_IRQ_EOT = 1;
  localparam int USR_PIN_CS = 0;
  localparam int USR_PIN_WR = 1;
  localparam int USR_PIN_RD = 2;
  localparam int USR_PIN_ALE = 3;
  localparam int USR_PIN_DMAW = 4;
  localparam int USR_PIN_DMAR = 5;
  localparam int USR_PIN_DMA_ACKNOWLEDGE = 6;
  localparam int USR_PIN_EOT = 7;
  localparam int USR_PIN_VBUS = 8;
  localparam int USR_PIN_SE0 = 9;
  localparam int USR_PIN_SUSP = 10;
  localparam int USR_PIN_W = 11;
  localparam int USR_CLK_MHZ = 100;
  localparam int USR_OSC_START_MS = 2;
  localparam int USR_OSC_START_CYC = USR_OSC_START_MS * 1000 * USR_CLK_MHZ;
  localparam int USR_BUSRST_NS = 2500;
  localparam int USR_BUSRST_CYC = USR_BUSRST_NS * USR_CLK_MHZ / 1000;
endpackage

// [sim/tb.sv]
// Self-checking bench for the reset, suspend and local pin block
`timescale 1ns/1ps
module tb;
  import usr_pkg::*;
  localparam int OSC = 20;
  logic clock, rst, psel, penable, pwrite, vbus, usb_se0, usb_suspend, buffer_ready;
  logic [7:0] paddr, local_data_bus, reg_target_addr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, pin_init_n, chip_sel_n, addr_latch_strobe, wr_strobe_n, rd_strobe_n;
  logic dma_wr_strobe_n, dma_rd_strobe_n, dma_acknowledge, transfer_end, osc_enable;
  logic [4:0] local_addr_bus;
  logic local_clock_out, local_clock_out_oe, intr_out_n, intr_out_n_oe, dma_request;
  logic dma_request_oe, dma_word_done, core_reset, usb_logic_reset, reg_access_strobe;
  logic reg_access_write, last_wr;
  int miscompares = 0;
  int checks_done = 0;
  int acc_cnt = 0;
  int wd_cnt = 0;
  usr_reset_pins #(.OSC_START_CYCLES(OSC)) i_dut (.clock, .rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .pin_init_n, .chip_sel_n,
    .addr_latch_strobe, .local_addr_bus, .local_data_bus, .wr_strobe_n, .rd_strobe_n,
    .dma_wr_strobe_n, .dma_rd_strobe_n, .dma_acknowledge, .transfer_end, .vbus, .usb_se0,
    .usb_suspend, .buffer_ready, .osc_enable, .local_clock_out, .local_clock_out_oe,
    .intr_out_n, .intr_out_n_oe, .dma_request, .dma_request_oe, .dma_word_done,
    .core_reset, .usb_logic_reset, .reg_target_addr, .reg_access_strobe, .reg_access_write);
  usr_cpu_model i_cpu (.clock, .pin_init_n, .chip_sel_n, .addr_latch_strobe,
    .local_addr_bus, .local_data_bus, .wr_strobe_n, .rd_strobe_n, .dma_wr_strobe_n,
    .dma_rd_strobe_n, .dma_acknowledge, .transfer_end);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (reg_access_strobe === 1'b1) begin
      acc_cnt++;
      last_wr = reg_access_write;
    end
    if (dma_word_done === 1'b1) wd_cnt++;
  end
  task end_of_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic er);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      end_of_test;
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
  endtask
  task wait_rst;
    int n;
    n = 0;
    while (core_reset !== 1'b0 && n < 64) begin
      @(posedge clock);
      n++;
    end
    if (n >= 64) begin
      miscompares++;
      end_of_test;
    end
  endtask
  task t_regs;
    logic [31:0] r;
    logic e;
    rd(USR_CTL_OFS, USR_CTL_RESET, "ctl_reset");
    wr(USR_DEV_ADDR_OFS, 32'h5A);
    rd(USR_DEV_ADDR_OFS, 32'h5A, "dev_addr");
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("unmapped_err", 1, e);
    chk("unmapped_data", 0, r);
    $display("t_regs done");
  endtask
  task t_local;
    int n0;
    n0 = acc_cnt;
    i_cpu.access(1'b1, 5'h03, 8'h5A, 1'b1);
    chk("direct", 8'h03, reg_target_addr);
    chk("wr_flag", 1, last_wr);
    i_cpu.access(1'b1, 5'h03, 8'h5A, 1'b0);
    chk("no_cs", n0 + 1, acc_cnt);
    i_cpu.access(1'b1, 5'h00, 8'h25, 1'b1);
    i_cpu.access(1'b0, 5'h01, 8'h00, 1'b1);
    chk("indirect", 8'h25, reg_target_addr);
    chk("rd_flag", 0, last_wr);
    i_cpu.latch(8'h07);
    i_cpu.access(1'b0, 5'h1E, 8'h00, 1'b1);
    chk("muxed", 8'h07, reg_target_addr);
    $display("t_local done");
  endtask
  task t_pinrst;
    logic v;
    wr(USR_CTL_OFS, 32'h105);
    wr(USR_DEV_ADDR_OFS, 32'h11);
    i_cpu.set(1'b0, 1'b1);
    cyc(6);
    i_cpu.set(1'b1, 1'b1);
    wait_rst;
    rd(USR_CTL_OFS, USR_CTL_RESET, "pin_ctl");
    rd(USR_DEV_ADDR_OFS, 0, "pin_addr");
    i_cpu.set(1'b0, 1'b0);
    cyc(8);
    chk("osc_held_off", 0, osc_enable);
    i_cpu.set(1'b1, 1'b1);
    wait_rst;
    cyc(OSC + 8);
    chk("osc_back", 1, osc_enable);
    chk("clk_back", 1, local_clock_out_oe);
    wr(USR_CTL_OFS, 32'h184);
    cyc(4);
    v = local_clock_out;
    cyc(3);
    chk("pwr_still", v, local_clock_out);
    $display("t_pinrst done");
  endtask
  task t_busrst;
    wr(USR_CTL_OFS, 32'h105);
    wr(USR_IRQ_EN_OFS, 32'h1);
    wr(USR_DEV_ADDR_OFS, 32'h33);
    vbus <= 1'b0;
    usb_se0 <= 1'b1;
    cyc(300);
    chk("no_vbus", 0, usb_logic_reset);
    vbus <= 1'b1;
    cyc(200);
    chk("short_se0", 0, usb_logic_reset);
    cyc(100);
    chk("bus_reset", 1, usb_logic_reset);
    rd(USR_DEV_ADDR_OFS, 0, "br_addr");
    rd(USR_CTL_OFS, 32'h105, "br_ctl");
    rd(USR_IRQ_STAT_OFS, 1, "br_start");
    chk("irq_pin", 1, intr_out_n_oe);
    wr(USR_IRQ_STAT_OFS, 32'h1);
    cyc(2);
    chk("irq_clear", 0, intr_out_n_oe);
    usb_se0 <= 1'b0;
    cyc(10);
    chk("br_end", 0, usb_logic_reset);
    rd(USR_IRQ_STAT_OFS, 1, "br_stop");
    $display("t_busrst done");
  endtask
  task t_dma;
    int n0;
    wr(USR_IRQ_STAT_OFS, 32'h3);
    wr(USR_IRQ_EN_OFS, 32'h2);
    buffer_ready <= 1'b1;
    wr(USR_CTL_OFS, 32'h13E);
    cyc(3);
    chk("dma_request_high", 1, dma_request);
    n0 = wd_cnt;
    i_cpu.dword(1'b0);
    chk("word_acked", n0 + 1, wd_cnt);
    wr(USR_CTL_OFS, 32'h13C);
    n0 = wd_cnt;
    i_cpu.dword(1'b1);
    chk("ack_ignored", n0 + 1, wd_cnt);
    wr(USR_CTL_OFS, 32'h138);
    cyc(3);
    chk("dma_request_low", 0, dma_request);
    i_cpu.end_pulse;
    chk("dma_request_stop", 1, dma_request);
    rd(USR_IRQ_STAT_OFS, 2, "end_flag");
    buffer_ready <= 1'b0;
    $display("t_dma done");
  endtask
  task t_susp;
    wr(USR_CTL_OFS, 32'h144);
    cyc(4);
    chk("susp_osc", 0, osc_enable);
    chk("susp_clk", 0, local_clock_out_oe);
    chk("susp_dma_request", 0, dma_request_oe);
    i_cpu.set(1'b1, 1'b0);
    cyc(8);
    chk("wake_osc", 1, osc_enable);
    chk("wake_clk", 0, local_clock_out_oe);
    i_cpu.set(1'b1, 1'b1);
    cyc(OSC + 4);
    chk("clk_on", 1, local_clock_out_oe);
    usb_suspend <= 1'b1;
    cyc(2);
    usb_suspend <= 1'b0;
    cyc(6);
    chk("host_susp", 0, osc_enable);
    $display("t_susp done");
  endtask
  initial begin
    {rst, psel, penable, pwrite, vbus, usb_se0, usb_suspend, buffer_ready} = 8'h80;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    cyc(2);
    wait_rst;
    t_regs;
    t_local;
    t_pinrst;
    t_busrst;
    t_dma;
    t_susp;
    end_of_test;
  end
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    end_of_test;
  end
endmodule

// [sim/usr_cpu_model.sv]
// Local CPU, reset source and fly-by DMA controller on the local pins
`timescale 1ns/1ps
module usr_cpu_model (
  input wire logic clock,
  output logic pin_init_n,
  output logic chip_sel_n,
  output logic addr_latch_strobe,
  output logic [4:0] local_addr_bus,
  output logic [7:0] local_data_bus,
  output logic wr_strobe_n,
  output logic rd_strobe_n,
  output logic dma_wr_strobe_n,
  output logic dma_rd_strobe_n,
  output logic dma_acknowledge,
  output logic transfer_end
);
  initial begin
    {pin_init_n, chip_sel_n, wr_strobe_n, rd_strobe_n} = 4'hF;
    {dma_wr_strobe_n, dma_rd_strobe_n} = 2'h3;
    {addr_latch_strobe, dma_acknowledge, transfer_end} = 3'h0;
    local_addr_bus = 5'h00;
    local_data_bus = 8'h00;
  end
  // Pins pass two sync stages, so access, latch and end_pulse levels stand four cycles
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask
  // caller keeps the reset level for at least five clocks
  task automatic set(input logic init_n, input logic cs_n);
    pin_init_n <= init_n;
    chip_sel_n <= cs_n;
    hold(1);
  endtask
  // one address bit reaches any register through the pointer
  task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d, input logic cs);
    local_addr_bus <= a;
    local_data_bus <= d;
    chip_sel_n <= !cs;
    hold(4);
    if (w) wr_strobe_n <= 1'b0;
    else rd_strobe_n <= 1'b0;
    hold(4);
    wr_strobe_n <= 1'b1;
    rd_strobe_n <= 1'b1;
    hold(4);
    chip_sel_n <= 1'b1;
    local_data_bus <= ~d;
    hold(4);
  endtask
  task automatic latch(input logic [7:0] a);
    local_data_bus <= a;
    addr_latch_strobe <= 1'b1;
    hold(4);
    addr_latch_strobe <= 1'b0;
    hold(4);
    local_data_bus <= ~a;
    hold(4);
  endtask
  // split bus words use only the DMA strobes
  task automatic dword(input logic rd);
    dma_acknowledge <= 1'b1;
    hold(2);
    if (rd) dma_rd_strobe_n <= 1'b0;
    else dma_wr_strobe_n <= 1'b0;
    hold(4);
    dma_rd_strobe_n <= 1'b1;
    dma_wr_strobe_n <= 1'b1;
    hold(2);
    dma_acknowledge <= 1'b0;
    hold(6);
  endtask
  task automatic end_pulse;
    transfer_end <= 1'b1;
    hold(4);
    transfer_end <= 1'b0;
    hold(6);
  endtask
endmodule

// [sim/usr_reset_pins_sva.sv]
// Checker for the reset, suspend and local pin block
`timescale 1ns/1ps
module usr_reset_pins_sva #(
  parameter int OSC_START_CYCLES = 20
) (
  input logic clock,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic pin_init_n,
  input logic vbus,
  input logic usb_se0,
  input logic osc_enable,
  input logic local_clock_out,
  input logic local_clock_out_oe,
  input logic dma_request_oe,
  input logic intr_out_n_oe,
  input logic core_reset,
  input logic usb_logic_reset
);
  default clocking cb @(posedge clock); endclocking
  // Saturates so a long run never wraps it
  int unsigned osc_cnt = 0;
  always_ff @(posedge clock) begin
    if (!osc_enable) begin
      osc_cnt <= 0;
    end else if (osc_cnt < OSC_START_CYCLES) begin
      osc_cnt <= osc_cnt + 1;
    end
  end
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence pin_quiet;
    pin_init_n [*4] ##0 $fell(rst);
  endsequence
  chk_rst_core: assert property (rst |=> core_reset)
    else $error("core reset missing");
  chk_rst_quiet: assert property (core_reset [*2] |-> !pready && !local_clock_out_oe
    && !intr_out_n_oe && usb_logic_reset) else $error("outputs active in reset");
  chk_rst_release: assert property (disable iff (rst) pin_quiet |=> !core_reset)
    else $error("reset release late");
  chk_apb_ready: assert property (disable iff (rst || core_reset)
    apb_setup |=> pready) else $error("no ready after setup");
  chk_ready_pulse: assert property (disable iff (rst) pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_pair: assert property (disable iff (rst) pslverr |-> pready)
    else $error("error without ready");
  chk_clk_osc: assert property (disable iff (rst) local_clock_out_oe |-> osc_enable)
    else $error("clock driven with oscillator off");
  chk_clk_start: assert property (disable iff (rst)
    $rose(local_clock_out_oe) |-> osc_cnt >= OSC_START_CYCLES - 1)
    else $error("clock driven too soon");
  chk_clk_frozen: assert property (disable iff (rst)
    !local_clock_out_oe [*2] |-> $stable(local_clock_out)) else $error("clock toggles");
  chk_dma_request_float: assert property (disable iff (rst)
    !dma_request_oe |=> !local_clock_out_oe) else $error("request float mismatch");
  chk_busrst_se0: assert property (disable iff (rst || core_reset)
    $rose(usb_logic_reset) ##1 !core_reset |-> $past(usb_se0, 251) && $past(vbus, 251))
    else $error("bus reset without long zero");
endmodule
bind usr_reset_pins usr_reset_pins_sva #(.OSC_START_CYCLES(OSC_START_CYCLES)) i_sva (
  .clock, .rst, .psel, .penable, .pready, .pslverr, .pin_init_n, .vbus, .usb_se0,
  .osc_enable, .local_clock_out, .local_clock_out_oe, .dma_request_oe, .intr_out_n_oe,
  .core_reset, .usb_logic_reset);

// [verilog/usr_reset_pins.sv]
// Reset, suspend, oscillator, local clock, local bus address and DMA pin logic
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module usr_reset_pins
  import usr_pkg::*;
#(
  parameter int OSC_START_CYCLES = USR_OSC_START_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_init_n,
  input wire logic chip_sel_n,
  input wire logic addr_latch_strobe,
  input wire logic [4:0] local_addr_bus,
  input wire logic [7:0] local_data_bus,
  input wire logic wr_strobe_n,
  input wire logic rd_strobe_n,
  input wire logic dma_wr_strobe_n,
  input wire logic dma_rd_strobe_n,
  input wire logic dma_acknowledge,
  input wire logic transfer_end,
  input wire logic vbus,
  input wire logic usb_se0,
  input wire logic usb_suspend,
  input wire logic buffer_ready,
  output logic osc_enable,
  output logic local_clock_out,
  output logic local_clock_out_oe,
  output logic intr_out_n,
  output logic intr_out_n_oe,
  output logic dma_request,
  output logic dma_request_oe,
  output logic dma_word_done,
  output logic core_reset,
  output logic usb_logic_reset,
  output logic [7:0] reg_target_addr,
  output logic reg_access_strobe,
  output logic reg_access_write
);

  logic init_s1_reg;
  logic init_s2_reg;
  logic core_rst_reg;
  logic [USR_PIN_W-1:0] pin_s1_reg;
  logic [USR_PIN_W-1:0] pin_s2_reg;
  logic [USR_PIN_W-1:0] pin_s3_reg;
  logic [4:0] la_s1_reg;
  logic [4:0] la_s2_reg;
  logic [7:0] ld_s1_reg;
  logic [7:0] ld_s2_reg;
  logic [15:0] ctl_reg;
  logic [1:0] irq_en_reg;
  logic [1:0] irq_stat_reg;
  logic [6:0] dev_addr_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic suspended_reg;
  logic osc_enable_reg;
  logic [17:0] osc_cnt_reg;
  logic osc_ready_reg;
  logic [2:0] div_cnt_reg;
  logic clk_out_reg;
  logic clk_oe_reg;
  logic [8:0] se0_cnt_reg;
  logic busrst_reg;
  logic usb_rst_reg;
  logic mux_seen_reg;
  logic [4:0] mux_addr_reg;
  logic [7:0] ptr_reg;
  logic [7:0] target_reg;
  logic access_reg;
  logic access_wr_reg;
  logic eot_pending_reg;
  logic eot_stop_reg;
  logic dma_request_reg;
  logic dma_request_oe_reg;
  logic word_done_reg;
  logic intr_oe_reg;

  logic apb_access;
  logic apb_wr;
  logic ctl_wr;
  logic cs_act;
  logic dma_acknowledge_act;
  logic eot_act;
  logic eot_edge;
  logic dma_edge;
  logic se0_hit;
  logic busrst_next;
  logic busrst_change;
  logic eot_stop_set;
  logic bus_end;
  logic [4:0] eff_addr;
  logic [31:0] status_word;
  logic dma_request_next;
  logic wr_end;

  assign apb_access = psel & penable & pready_reg;
  assign apb_wr = apb_access & pwrite;
  assign ctl_wr = apb_wr & (paddr == USR_CTL_OFS);
  assign cs_act = ~pin_s2_reg[USR_PIN_CS];
  assign dma_acknowledge_act = ctl_reg[USR_CTL_ACK_EN]
                    & (pin_s2_reg[USR_PIN_DMA_ACKNOWLEDGE] == ctl_reg[USR_CTL_DMA_ACKNOWLEDGE_POL]);
  // Transfer end level follows its programmed polarity
  assign eot_act = pin_s2_reg[USR_PIN_EOT] == ctl_reg[USR_CTL_EOT_POL];
  assign eot_edge = eot_act & (pin_s3_reg[USR_PIN_EOT] != ctl_reg[USR_CTL_EOT_POL]);
  // Word completes on the rising edge of either DMA strobe
  assign dma_edge = (pin_s2_reg[USR_PIN_DMAW] & ~pin_s3_reg[USR_PIN_DMAW])
                    | (pin_s2_reg[USR_PIN_DMAR] & ~pin_s3_reg[USR_PIN_DMAR]);
  // Detection only with VBUS present and enabled
  assign se0_hit = pin_s2_reg[USR_PIN_SE0] & pin_s2_reg[USR_PIN_VBUS]
                   & ctl_reg[USR_CTL_DETECT_EN];
  // Reset seen once SE0 outlasts the minimum
  assign busrst_next = se0_hit & (se0_cnt_reg >= 9'(USR_BUSRST_CYC));
  assign busrst_change = busrst_next != busrst_reg;
  assign eot_stop_set = (eot_edge | eot_pending_reg) & ~dma_acknowledge_act;
  assign bus_end = ~pin_s3_reg[USR_PIN_CS]
                   & ((pin_s2_reg[USR_PIN_WR] & ~pin_s3_reg[USR_PIN_WR])
                   | (~pin_s2_reg[USR_PIN_RD] & pin_s3_reg[USR_PIN_RD]));
  // Only a rising write strobe marks a write; a read leaves the write strobe idle high
  assign wr_end = pin_s2_reg[USR_PIN_WR] & ~pin_s3_reg[USR_PIN_WR];
  // Latched address takes over once the strobe has been seen
  assign eff_addr = mux_seen_reg ? mux_addr_reg : la_s2_reg;
  assign status_word = {19'h0, mux_addr_reg, 3'h0, clk_oe_reg, osc_ready_reg,
                        pin_s2_reg[USR_PIN_VBUS], busrst_reg, suspended_reg};
  assign dma_request_next = ~((ctl_reg[USR_CTL_DMA_EN] & buffer_ready & ~eot_stop_reg
                      & ~eot_pending_reg & ~eot_edge & ~busrst_reg & ~suspended_reg)
                      ^ ctl_reg[USR_CTL_DMA_REQUEST_POL]);

  // Pin synchronisers; the third stage only feeds edge detection
  always_ff @(posedge clock) begin
    if (rst) begin
      // Idle pin levels, so no false edge follows reset
      init_s1_reg <= 1'b1;
      init_s2_reg <= 1'b1;
      pin_s1_reg <= 11'h037;
      pin_s2_reg <= 11'h037;
      pin_s3_reg <= 11'h037;
    end else begin
      init_s1_reg <= pin_init_n;
      init_s2_reg <= init_s1_reg;
      pin_s1_reg <= {usb_suspend, usb_se0, vbus, transfer_end, dma_acknowledge,
                     dma_rd_strobe_n, dma_wr_strobe_n, addr_latch_strobe, rd_strobe_n,
                     wr_strobe_n, chip_sel_n};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  always_ff @(posedge clock) begin
    la_s1_reg <= local_addr_bus;
    la_s2_reg <= la_s1_reg;
    ld_s1_reg <= local_data_bus;
    ld_s2_reg <= ld_s1_reg;
  end

  // One registered reset, released at once for all state except the pin synchronisers, which follow rst
  always_ff @(posedge clock) begin
    core_rst_reg <= rst | ~init_s2_reg;
  end

  // APB slave, no wait states, error on unmapped offsets
  always_ff @(posedge clock) begin
    if (core_rst_reg) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel & ~penable;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      if (psel & ~penable) begin
        unique case (paddr)
          USR_CTL_OFS: prdata_reg <= {16'h0, ctl_reg};
          USR_IRQ_EN_OFS: prdata_reg <= {30'h0, irq_en_reg};
          USR_IRQ_STAT_OFS: prdata_reg <= {30'h0, irq_stat_reg};
          USR_STATUS_OFS: prdata_reg <= status_word;
          USR_DEV_ADDR_OFS: prdata_reg <= {25'h0, dev_addr_reg};
          default: pslverr_reg <= 1'b1;
        endcase
      end
    end
  end

  // Configuration registers return to defaults on reset pin
  always_ff @(posedge clock) begin
    if (core_rst_reg) begin
      ctl_reg <= USR_CTL_RESET;
      irq_en_reg <= 2'h0;
    end else if (apb_wr) begin
      // Suspend bit is a command and is never stored
      if (paddr == USR_CTL_OFS) begin
        ctl_reg <= pwdata[15:0] & ~(16'h0001 << USR_CTL_SUSPEND);
      end
      if (paddr == USR_IRQ_EN_OFS) begin
        irq_en_reg <= pwdata[1:0];
      end
    end
  end

  // Device address cleared by bus reset, other config kept
  always_ff @(posedge clock) begin
    if (core_rst_reg || busrst_reg) begin
      dev_addr_reg <= 7'h00;
    end else if (apb_wr && paddr == USR_DEV_ADDR_OFS) begin
      dev_addr_reg <= pwdata[6:0];
    end
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clock) begin
    if (core_rst_reg) begin
      irq_stat_reg <= 2'h0;
    end else begin
      if (apb_wr && paddr == USR_IRQ_STAT_OFS) begin
        irq_stat_reg <= irq_stat_reg & ~pwdata[1:0];
      end
      // Both edges of bus reset raise the flag
      if (busrst_change) begin
        irq_stat_reg[USR_IRQ_BUSRST] <= 1'b1;
      end
      if (eot_stop_set) begin
        irq_stat_reg[USR_IRQ_EOT] <= 1'b1;
      end
    end
  end

  // Open drain: enable drives the pin low
  always_ff @(posedge clock) begin
    if (core_rst_reg) begin
      intr_oe_reg <= 1'b0;
    end else begin
      intr_oe_reg <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // Suspend entry by host detection or command, exit by chip select
  always_ff @(posedge clock) begin
    if (core_rst_reg) begin
      suspended_reg <= 1'b0;
    end else if (suspended_reg && cs_act) begin
      suspended_reg <= 1'b0;
    end else if ((pin_s2_reg[USR_PIN_SUSP] || (ctl_wr && pwdata[USR_CTL_SUSPEND]))
                 && !cs_act) begin
      suspended_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (core_rst_reg) begin
      // Chip select during reset keeps the oscillator off
      osc_enable_reg <= ~cs_act;
    end else begin
      osc_enable_reg <= ~suspended_reg;
    end
  end

  // Start-up count before the clock output may drive
  always_ff @(posedge clock) begin
    if (core_rst_reg || !osc_enable_reg) begin
      osc_cnt_reg <= 18'h0;
      osc_ready_reg <= 1'b0;
    end else if (osc_cnt_reg >= 18'(OSC_START_CYCLES - 1)) begin
      osc_ready_reg <= 1'b1;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 18'h1;
    end
  end

  // Divider sets the local clock rate; enable pulse toggles the pin
  always_ff @(posedge clock) begin
    if (core_rst_reg || div_cnt_reg == ctl_reg[USR_CTL_DIV_LSB +: 3]) begin
      div_cnt_reg <= 3'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (core_rst_reg) begin
      clk_out_reg <= 1'b0;
      clk_oe_reg <= 1'b0;
    end else begin
      // Stops immediately on suspend; floats with host suspend, but one cycle after suspended_reg sets on a command
      clk_oe_reg <= osc_ready_reg & ~suspended_reg & ~pin_s2_reg[USR_PIN_SUSP]
                    & ctl_reg[USR_CTL_CLK_EN];
      // Power-down holds the pin still
      // Holding the level avoids a late edge on a pin that has just floated
      if (!osc_ready_reg || suspended_reg || pin_s2_reg[USR_PIN_SUSP]
          || (ctl_wr && pwdata[USR_CTL_SUSPEND]) || ctl_reg[USR_CTL_PWR_DOWN]
          || !ctl_reg[USR_CTL_CLK_EN]) begin
        clk_out_reg <= clk_out_reg;
      end else if (div_cnt_reg == ctl_reg[USR_CTL_DIV_LSB +: 3]) begin
        clk_out_reg <= ~clk_out_reg;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (core_rst_reg || !se0_hit) begin
      se0_cnt_reg <= 9'h0;
    end else if (se0_cnt_reg < 9'(USR_BUSRST_CYC)) begin
      se0_cnt_reg <= se0_cnt_reg + 9'h1;
    end
  end

  // USB side logic held while bus reset lasts
  always_ff @(posedge clock) begin
    if (core_rst_reg) begin
      busrst_reg <= 1'b0;
      usb_rst_reg <= 1'b1;
    end else begin
      busrst_reg <= busrst_next;
      usb_rst_reg <= busrst_next;
    end
  end

  // Falling strobe latches the low data bits
  always_ff @(posedge clock) begin
    if (core_rst_reg) begin
      mux_seen_reg <= 1'b0;
      mux_addr_reg <= 5'h00;
    end else if (~pin_s2_reg[USR_PIN_ALE] & pin_s3_reg[USR_PIN_ALE]) begin
      mux_seen_reg <= 1'b1;
      mux_addr_reg <= ld_s2_reg[4:0];
    end
  end

  // Offset 0 holds the pointer, offset 1 reaches through it
  always_ff @(posedge clock) begin
    if (core_rst_reg || busrst_reg) begin
      ptr_reg <= 8'h00;
      target_reg <= 8'h00;
      access_reg <= 1'b0;
      access_wr_reg <= 1'b0;
    end else begin
      access_reg <= bus_end;
      access_wr_reg <= bus_end & wr_end;
      if (bus_end) begin
        target_reg <= (eff_addr == 5'h01) ? ptr_reg : {3'h0, eff_addr};
        if (wr_end && eff_addr == 5'h00) begin
          ptr_reg <= ld_s2_reg;
        end
      end
    end
  end

  // Stop after the word in progress completes
  always_ff @(posedge clock) begin
    if (core_rst_reg || busrst_reg) begin
      eot_pending_reg <= 1'b0;
      eot_stop_reg <= 1'b0;
    end else begin
      eot_pending_reg <= (eot_edge | eot_pending_reg) & dma_acknowledge_act;
      // Rewriting control restarts requests; a stop in the same cycle wins
      if (eot_stop_set) begin
        eot_stop_reg <= 1'b1;
      end else if (ctl_wr) begin
        eot_stop_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (core_rst_reg) begin
      dma_request_reg <= ~USR_CTL_RESET[USR_CTL_DMA_REQUEST_POL];
      dma_request_oe_reg <= 1'b1;
      word_done_reg <= 1'b0;
    end else begin
      dma_request_reg <= dma_request_next;
      dma_request_oe_reg <= ~suspended_reg;
      word_done_reg <= dma_edge & (dma_acknowledge_act | ~ctl_reg[USR_CTL_ACK_EN]);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign osc_enable = osc_enable_reg;
  assign local_clock_out = clk_out_reg;
  assign local_clock_out_oe = clk_oe_reg;
  assign intr_out_n = 1'b0;
  assign intr_out_n_oe = intr_oe_reg;
  assign dma_request = dma_request_reg;
  assign dma_request_oe = dma_request_oe_reg;
  assign dma_word_done = word_done_reg;
  assign core_reset = core_rst_reg;
  assign usb_logic_reset = usb_rst_reg;
  assign reg_target_addr = target_reg;
  assign reg_access_strobe = access_reg;
  assign reg_access_write = access_wr_reg;

endmodule
